//--- phy_reset_power_control_params.svh
// constants for the reset and power-state control block
`ifndef PHY_RESET_POWER_CONTROL_PARAMS_SVH
`define PHY_RESET_POWER_CONTROL_PARAMS_SVH

// register indices (byte address is four times the index)
`define REG_IDX_BASIC_MODE_CONTROL 5'h00
`define REG_IDX_BASIC_MODE_STATUS 5'h01
`define REG_IDX_IDENTIFIER_WORD_ONE 5'h02
`define REG_IDX_IDENTIFIER_WORD_TWO 5'h03
`define REG_IDX_NEGOTIATION_ADVERTISE 5'h04
`define REG_IDX_PARTNER_ABILITY 5'h05
`define REG_IDX_ENERGY_DETECT_CONTROL 5'h1d
`define REG_IDX_POWER_STATUS 5'h1e

// basic mode control fields
`define BMC_SOFT_RESET_BIT 15
`define BMC_POWER_DOWN_BIT 11

// energy detect control fields
`define EDC_ENABLE_BIT 15

// reset values
`define BMC_RESET_VALUE 16'h3100
`define BMS_RESET_VALUE 16'h7849
`define ADV_RESET_VALUE 16'h01e1
`define PARTNER_RESET_VALUE 16'h0000
`define EDC_RESET_VALUE 16'h0000
// identifier words: arbitrary neutral values
`define ID_ONE_VALUE 16'h1234
`define ID_TWO_VALUE 16'h5670

// timing
`define CLK_PERIOD_NS 50
`define SOFT_RESET_NS 1000
`define SOFT_RESET_CYCLES (`SOFT_RESET_NS / `CLK_PERIOD_NS)
`define HW_RESET_MIN_NS 1000
`define HW_RESET_MIN_CYCLES ((`HW_RESET_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define POR_NS 1000
`define POR_CYCLES (`POR_NS / `CLK_PERIOD_NS)
`define POWER_UP_NS 2000
`define POWER_UP_CYCLES (`POWER_UP_NS / `CLK_PERIOD_NS)
`define PULSE_PERIOD_CYCLES 4000
`define PULSE_WIDTH_CYCLES 2
`define TIMER_WIDTH 12

`endif

//--- phy_reset_power_control_pkg.sv
// types shared by the reset and power-state control block
package phy_reset_power_control_pkg;
	typedef enum logic [2:0] {
		ST_RESET = 3'b000,
		ST_POWER_UP = 3'b001,
		ST_NORMAL = 3'b010,
		ST_POWER_DOWN = 3'b011,
		ST_ENERGY_SLEEP = 3'b100
	} power_state_type;

	typedef struct packed {
		logic link_active;
		logic tx_enable;
		logic energy_pulse;
		logic core_reset_n;
	} line_ctrl_type;
endpackage : phy_reset_power_control_pkg

//--- reset_timer.sv
// down counter that holds busy high until a loaded count has expired
`timescale 1ns/10ps
`include "phy_reset_power_control_params.svh"
module reset_timer (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic load,
	input wire logic [`TIMER_WIDTH-1:0] count,
	output logic busy
);
	logic [`TIMER_WIDTH-1:0] left_q;

	// reload wins over counting so a retrigger restarts the full span
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			left_q <= 12'h000;
		end else if (load) begin
			left_q <= count;
		end else if (left_q != 12'h000) begin
			left_q <= left_q - 12'h001;
		end
	end

	assign busy = (left_q != 12'h000);
endmodule : reset_timer

//--- phy_reset_power_control.sv
// reset and power-state control with an apb register file
// Function
// - Writing one to control bit 11 at index zero puts the device into power-down.
// - With energy detect enabled and no line activity the device sleeps in low power while watching the line.
// - Line activity seen while asleep makes the device run its normal power-up sequence.
// - In energy-detect mode the transmitter is woken periodically to send pulses, regardless of activity.
// - Energy detect is enabled and configured through the control register at index 0x1d.
// - The device makes its own power-on reset, armed when the external presetn releases.
// - A hardware reset restores every register default and re-latches the straps.
// - Writing one to control bit 15 starts a software reset.
// - A software reset completes about one microsecond after the write.
// - A software reset returns all registers to their defaults.
`timescale 1ns/10ps
`include "phy_reset_power_control_params.svh"
module phy_reset_power_control
	import phy_reset_power_control_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic reset_pin_n,
	input wire logic [3:0] strap_pins,
	input wire logic line_energy,
	output phy_reset_power_control_pkg::line_ctrl_type line_ctrl,
	output logic [3:0] strap_latched,
	output phy_reset_power_control_pkg::power_state_type power_state
);
	import phy_reset_power_control_pkg::*;

	localparam int SOFT_CYC = `SOFT_RESET_CYCLES;
	localparam int HW_CYC = `HW_RESET_MIN_CYCLES;
	localparam int POR_CYC = `POR_CYCLES;
	localparam int UP_CYC = `POWER_UP_CYCLES;

	// decodes a register index from a byte address; unaligned gives an invalid index
	function automatic logic [5:0] reg_index(input logic [7:0] addr);
		reg_index = (addr[1:0] == 2'b00 && !addr[7]) ? {1'b0, addr[6:2]} : 6'h3f;
	endfunction : reg_index

	// tells whether an index names a mapped register
	function automatic logic reg_mapped(input logic [5:0] idx);
		case (idx[4:0])
			`REG_IDX_BASIC_MODE_CONTROL, `REG_IDX_BASIC_MODE_STATUS, `REG_IDX_IDENTIFIER_WORD_ONE,
			`REG_IDX_IDENTIFIER_WORD_TWO, `REG_IDX_NEGOTIATION_ADVERTISE, `REG_IDX_PARTNER_ABILITY,
			`REG_IDX_ENERGY_DETECT_CONTROL, `REG_IDX_POWER_STATUS: reg_mapped = !idx[5];
			default: reg_mapped = 1'b0;
		endcase
	endfunction : reg_mapped

	logic [1:0] pin_sync_q;
	logic [1:0] energy_sync_q;
	logic [7:0] strap_sync_q;
	logic [4:0] pin_low_cnt_q;
	logic [15:0] bmc_q, adv_q, partner_q, edc_q, bms_q;
	logic [3:0] strap_q;
	logic [11:0] pulse_cnt_q;
	logic [5:0] acc_idx;
	logic [15:0] rd_word;
	power_state_type state_q, state_d;
	logic pin_low, energy_seen, hw_reset_q, strap_take_q;
	logic por_busy, por_load_q, soft_busy, soft_load, soft_active_q, regs_init;
	logic up_load, up_busy, pulse_q, wr_en;

	// two flops on every pin input before any logic reads it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_sync_q <= 2'b11;
			energy_sync_q <= 2'b00;
			strap_sync_q <= 8'h00;
		end else begin
			pin_sync_q <= {pin_sync_q[0], reset_pin_n};
			energy_sync_q <= {energy_sync_q[0], line_energy};
			strap_sync_q <= {strap_sync_q[3:0], strap_pins};
		end
	end
	assign pin_low = !pin_sync_q[1];
	assign energy_seen = energy_sync_q[1];

	// the pin must stay low a full microsecond before it counts, glitches are ignored
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_low_cnt_q <= 5'h00;
			hw_reset_q <= 1'b0;
		end else begin
			if (!pin_low) begin
				pin_low_cnt_q <= 5'h00;
				hw_reset_q <= 1'b0;
			end else if (pin_low_cnt_q != 5'(HW_CYC)) begin
				pin_low_cnt_q <= pin_low_cnt_q + 5'h01;
			end else begin
				hw_reset_q <= 1'b1;
			end
		end
	end

	// internal power-on reset: the timer is armed once after presetn releases
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			por_load_q <= 1'b1;
		end else begin
			por_load_q <= 1'b0;
		end
	end

	reset_timer por_timer (
		.pclk(pclk),
		.presetn(presetn),
		.load(por_load_q),
		.count(12'(POR_CYC)),
		.busy(por_busy)
	);

	assign wr_en = psel && penable && pwrite;
	assign acc_idx = reg_index(paddr);
	assign soft_load = wr_en && acc_idx[4:0] == `REG_IDX_BASIC_MODE_CONTROL && !acc_idx[5]
		&& pwdata[`BMC_SOFT_RESET_BIT] && !soft_busy;

	reset_timer soft_timer (
		.pclk(pclk),
		.presetn(presetn),
		.load(soft_load),
		.count(12'(SOFT_CYC)),
		.busy(soft_busy)
	);

	// software reset runs from the write until the timer has drained
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			soft_active_q <= 1'b0;
		end else if (soft_load) begin
			soft_active_q <= 1'b1;
		end else if (!soft_busy) begin
			soft_active_q <= 1'b0;
		end
	end

	// any reset source forces defaults; por_load_q covers the cycle before the timer is armed
	assign regs_init = por_load_q || por_busy || hw_reset_q || (soft_active_q && !soft_busy);

	// straps are caught by a clocked process when the pin or power-on reset ends
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			strap_take_q <= 1'b1;
			strap_q <= 4'h0;
		end else begin
			strap_take_q <= por_busy || hw_reset_q; // a glitch shorter than a reset leaves the straps alone
			if (strap_take_q) begin
				strap_q <= strap_sync_q[7:4];
			end
		end
	end
	assign strap_latched = strap_q;

	// control register; the reset bit reads one until the reset finishes, then clears
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bmc_q <= `BMC_RESET_VALUE;
		end else if (regs_init) begin
			bmc_q <= `BMC_RESET_VALUE;
		end else if (wr_en && acc_idx == {1'b0, `REG_IDX_BASIC_MODE_CONTROL}) begin
			bmc_q <= pwdata[15:0];
		end
	end

	// writable negotiation and energy detect registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			adv_q <= `ADV_RESET_VALUE;
			partner_q <= `PARTNER_RESET_VALUE;
			edc_q <= `EDC_RESET_VALUE;
		end else if (regs_init) begin
			adv_q <= `ADV_RESET_VALUE;
			partner_q <= `PARTNER_RESET_VALUE;
			edc_q <= `EDC_RESET_VALUE;
		end else if (wr_en && !soft_active_q) begin
			if (acc_idx == {1'b0, `REG_IDX_NEGOTIATION_ADVERTISE}) begin
				adv_q <= pwdata[15:0];
			end
			if (acc_idx == {1'b0, `REG_IDX_PARTNER_ABILITY}) begin
				partner_q <= pwdata[15:0];
			end
			if (acc_idx == {1'b0, `REG_IDX_ENERGY_DETECT_CONTROL}) begin
				edc_q <= pwdata[15:0];
			end
		end
	end

	// status word mirrors a default plus the live energy state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bms_q <= `BMS_RESET_VALUE;
		end else begin
			bms_q <= `BMS_RESET_VALUE | {13'h0000, energy_seen, 2'b00};
		end
	end

	// power state sequence
	always_comb begin
		state_d = state_q;
		up_load = 1'b0;
		case (state_q)
			ST_RESET: begin
				if (!regs_init) begin
					state_d = ST_POWER_UP;
					up_load = 1'b1;
				end
			end
			ST_POWER_UP: begin
				if (bmc_q[`BMC_POWER_DOWN_BIT]) begin
					state_d = ST_POWER_DOWN;
				end else if (!up_busy) begin
					state_d = ST_NORMAL;
				end
			end
			ST_NORMAL: begin
				if (bmc_q[`BMC_POWER_DOWN_BIT]) begin
					state_d = ST_POWER_DOWN;
				end else if (edc_q[`EDC_ENABLE_BIT] && !energy_seen) begin
					state_d = ST_ENERGY_SLEEP;
				end
			end
			ST_POWER_DOWN: begin
				if (!bmc_q[`BMC_POWER_DOWN_BIT]) begin
					state_d = ST_POWER_UP;
					up_load = 1'b1;
				end
			end
			ST_ENERGY_SLEEP: begin
				if (bmc_q[`BMC_POWER_DOWN_BIT]) begin
					state_d = ST_POWER_DOWN;
				end else if (energy_seen || !edc_q[`EDC_ENABLE_BIT]) begin
					state_d = ST_POWER_UP;
					up_load = 1'b1;
				end
			end
			default: begin
				state_d = ST_RESET;
			end
		endcase
		if (regs_init) begin
			state_d = ST_RESET;
			up_load = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= ST_RESET;
		end else begin
			state_q <= state_d;
		end
	end
	assign power_state = state_q;

	reset_timer up_timer (
		.pclk(pclk),
		.presetn(presetn),
		.load(up_load),
		.count(12'(UP_CYC)),
		.busy(up_busy)
	);

	// pulse period runs whenever energy detect is enabled, asleep or awake, except in power-down and reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pulse_cnt_q <= 12'h000;
			pulse_q <= 1'b0;
		end else if (!edc_q[`EDC_ENABLE_BIT] || state_q == ST_POWER_DOWN || state_q == ST_RESET) begin
			pulse_cnt_q <= 12'h000;
			pulse_q <= 1'b0;
		end else if (pulse_cnt_q == 12'(`PULSE_PERIOD_CYCLES - 1)) begin
			pulse_cnt_q <= 12'h000;
			pulse_q <= 1'b1;
		end else begin
			pulse_cnt_q <= pulse_cnt_q + 12'h001;
			if (pulse_cnt_q == 12'(`PULSE_WIDTH_CYCLES - 1)) begin
				pulse_q <= 1'b0;
			end
		end
	end

	// line outputs; in sleep the transmitter wakes only for pulses
	assign line_ctrl.link_active = (state_q == ST_NORMAL);
	assign line_ctrl.tx_enable = (state_q == ST_NORMAL) || pulse_q;
	assign line_ctrl.energy_pulse = pulse_q;
	assign line_ctrl.core_reset_n = !regs_init;

	// read mux
	always_comb begin
		case (acc_idx)
			{1'b0, `REG_IDX_BASIC_MODE_CONTROL}: rd_word = bmc_q;
			{1'b0, `REG_IDX_BASIC_MODE_STATUS}: rd_word = bms_q;
			{1'b0, `REG_IDX_IDENTIFIER_WORD_ONE}: rd_word = `ID_ONE_VALUE;
			{1'b0, `REG_IDX_IDENTIFIER_WORD_TWO}: rd_word = `ID_TWO_VALUE;
			{1'b0, `REG_IDX_NEGOTIATION_ADVERTISE}: rd_word = adv_q;
			{1'b0, `REG_IDX_PARTNER_ABILITY}: rd_word = partner_q;
			{1'b0, `REG_IDX_ENERGY_DETECT_CONTROL}: rd_word = edc_q;
			{1'b0, `REG_IDX_POWER_STATUS}: rd_word = {9'h000, strap_q, state_q};
			default: rd_word = 16'h0000;
		endcase
	end

	// read data registered at the setup cycle so the access phase completes at once
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			prdata <= {16'h0000, rd_word};
		end
	end

	assign pready = 1'b1;
	assign pslverr = psel && penable && !reg_mapped(acc_idx);

	// assertions
	soft_bit_clears_a: assert property (@(posedge pclk) disable iff (!presetn)
		soft_load |-> ##22 !bmc_q[`BMC_SOFT_RESET_BIT])
		else $error("soft reset bit did not clear");
	soft_duration_a: assert property (@(posedge pclk) disable iff (!presetn)
		soft_load |=> soft_active_q[*8])
		else $error("soft reset ended early");
	power_down_a: assert property (@(posedge pclk) disable iff (!presetn)
		(state_q == ST_NORMAL && bmc_q[`BMC_POWER_DOWN_BIT] && !regs_init) |=> state_q == ST_POWER_DOWN)
		else $error("power down not entered");
	sleep_entry_a: assert property (@(posedge pclk) disable iff (!presetn)
		(state_q == ST_NORMAL && edc_q[`EDC_ENABLE_BIT] && !energy_seen && !bmc_q[`BMC_POWER_DOWN_BIT] && !regs_init)
		|=> state_q == ST_ENERGY_SLEEP)
		else $error("energy sleep not entered");
	wake_up_a: assert property (@(posedge pclk) disable iff (!presetn)
		(state_q == ST_ENERGY_SLEEP && energy_seen && !bmc_q[`BMC_POWER_DOWN_BIT] && !regs_init)
		|=> state_q == ST_POWER_UP)
		else $error("no wake on energy");
	pulse_in_sleep_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(pulse_q) |-> line_ctrl.tx_enable && $past(pulse_cnt_q) == 12'(`PULSE_PERIOD_CYCLES - 1))
		else $error("pulse without transmitter");
	defaults_on_init_a: assert property (@(posedge pclk) disable iff (!presetn)
		regs_init |=> (bmc_q == `BMC_RESET_VALUE && edc_q == `EDC_RESET_VALUE))
		else $error("registers not restored");
	hw_reset_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(hw_reset_q) |-> $past(pin_low, 20))
		else $error("hardware reset taken from a short pulse");
	por_init_a: assert property (@(posedge pclk) disable iff (!presetn)
		por_busy |-> !line_ctrl.core_reset_n)
		else $error("power-on reset not applied");
	edc_write_a: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_en && acc_idx == {1'b0, `REG_IDX_ENERGY_DETECT_CONTROL} && !soft_active_q && !regs_init)
		|=> edc_q == $past(pwdata[15:0]))
		else $error("energy detect control not written");
	soft_reset_c: cover property (@(posedge pclk) disable iff (!presetn) soft_load ##[1:30] !soft_active_q);
	sleep_wake_c: cover property (@(posedge pclk) disable iff (!presetn)
		state_q == ST_ENERGY_SLEEP ##1 state_q == ST_POWER_UP);
	hw_reset_c: cover property (@(posedge pclk) disable iff (!presetn) $rose(hw_reset_q));
endmodule : phy_reset_power_control

//--- board_model.sv
// board-side partner: reset pin driver, strap levels and line energy
`timescale 1ns/10ps
module board_model (
	input wire logic pclk,
	output logic reset_pin_n,
	output logic [3:0] strap_pins,
	output logic line_energy
);
	// quiet board at power-up: pin released, idle line
	initial begin
		reset_pin_n = 1'b1;
		strap_pins = 4'ha;
		line_energy = 1'b0;
	end

	// pulse the reset pin low; straps move only while it is low, so the latch sees them settled
	task pin_reset(input int low_cycles, input logic [3:0] straps);
		@(posedge pclk);
		reset_pin_n <= 1'b0;
		strap_pins <= straps;
		repeat (low_cycles) @(posedge pclk);
		reset_pin_n <= 1'b1;
	endtask : pin_reset

	// cable activity as a plain level
	task set_energy(input logic level);
		@(posedge pclk);
		line_energy <= level;
	endtask : set_energy
endmodule : board_model

//--- test_phy_reset_power_control.sv
// self-checking bench for the reset and power-state control block
`timescale 1ns/10ps
`include "phy_reset_power_control_params.svh"
module test_phy_reset_power_control;
	import phy_reset_power_control_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, reset_pin_n, line_energy;
	logic [3:0] strap_pins, strap_latched;
	line_ctrl_type line_ctrl;
	power_state_type power_state;
	int miscompares = 0;
	int num_checks = 0;
	int cycles = 0;
	int i, t0;
	logic [31:0] rdata;
	logic err;
	logic [7:0] reg_addr [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h74};
	logic [15:0] reg_def [7] = '{`BMC_RESET_VALUE, `BMS_RESET_VALUE, `ID_ONE_VALUE, `ID_TWO_VALUE,
		`ADV_RESET_VALUE, `PARTNER_RESET_VALUE, `EDC_RESET_VALUE};

	phy_reset_power_control i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .reset_pin_n(reset_pin_n), .strap_pins(strap_pins),
		.line_energy(line_energy), .line_ctrl(line_ctrl), .strap_latched(strap_latched),
		.power_state(power_state));
	board_model i_board (.pclk(pclk), .reset_pin_n(reset_pin_n), .strap_pins(strap_pins),
		.line_energy(line_energy));

	always #25 pclk = ~pclk;

	// hang guard: the whole sequence needs well under twenty thousand cycles
	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			miscompares++;
			give_verdict();
		end
	end

	task give_verdict();
		if (miscompares == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : give_verdict

	task chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// one apb transfer; request held until pready is seen high at a rising edge
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rdata = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task chk_defaults();
		for (int k = 0; k < 7; k++) begin
			apb(1'b0, reg_addr[k], 32'h0);
			chk(rdata, {16'h0, reg_def[k]});
		end
	endtask : chk_defaults

	task wait_core();
		for (i = 0; i < 100 && line_ctrl.core_reset_n !== 1'b1; i++) @(posedge pclk);
		chk({31'h0, line_ctrl.core_reset_n}, 32'h1);
	endtask : wait_core

	task wait_state(input power_state_type s, input int lim);
		for (i = 0; i < lim && power_state !== s; i++) @(posedge pclk);
		chk({29'h0, power_state}, {29'h0, s});
	endtask : wait_state

	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		// own power-on reset, then defaults and straps
		wait_core();
		wait_state(ST_NORMAL, 60);
		chk({28'h0, strap_latched}, 32'h0000_000a);
		chk_defaults();
		apb(1'b0, 8'h78, 32'h0);
		chk(rdata, {25'h0, 4'ha, 3'd2});
		// plain access, read-only and unmapped places
		apb(1'b1, 8'h10, 32'h0000_0a5a);
		apb(1'b1, 8'h04, 32'h0000_ffff);
		apb(1'b0, 8'h10, 32'h0);
		chk(rdata, 32'h0000_0a5a);
		apb(1'b0, 8'h04, 32'h0);
		chk(rdata, {16'h0, `BMS_RESET_VALUE});
		apb(1'b0, 8'h40, 32'h0);
		chk({rdata[30:0], err}, 32'h1);
		// software reset: bit reads one, clears after about a microsecond, defaults back
		apb(1'b1, 8'h00, 32'h0000_8000);
		t0 = cycles;
		apb(1'b0, 8'h00, 32'h0);
		chk({31'h0, rdata[`BMC_SOFT_RESET_BIT]}, 32'h1);
		for (int k = 0; k < 20 && rdata[`BMC_SOFT_RESET_BIT] !== 1'b0; k++) apb(1'b0, 8'h00, 32'h0);
		chk(32'(cycles - t0 >= `SOFT_RESET_CYCLES - 2 && cycles - t0 <= `SOFT_RESET_CYCLES + 6), 32'h1);
		chk(rdata, {16'h0, `BMC_RESET_VALUE});
		chk_defaults();
		// power-down and back
		apb(1'b1, 8'h00, 32'(`BMC_RESET_VALUE) | (32'h1 << `BMC_POWER_DOWN_BIT));
		wait_state(ST_POWER_DOWN, 3);
		apb(1'b1, 8'h00, {16'h0, `BMC_RESET_VALUE});
		wait_state(ST_POWER_UP, 3);
		wait_state(ST_NORMAL, 50);
		// too short a pin pulse is ignored, a full one resets and re-latches straps
		apb(1'b1, 8'h10, 32'h0000_0a5a);
		i_board.pin_reset(10, 4'h5);
		repeat (4) @(posedge pclk);
		apb(1'b0, 8'h10, 32'h0);
		chk(rdata, 32'h0000_0a5a);
		chk({28'h0, strap_latched}, 32'h0000_000a);
		i_board.pin_reset(`HW_RESET_MIN_CYCLES + 2, 4'h5);
		// the pin is synchronised and counted first, so the internal reset starts a few cycles late
		for (i = 0; i < 30 && line_ctrl.core_reset_n !== 1'b0; i++) @(posedge pclk);
		chk({31'h0, line_ctrl.core_reset_n}, 32'h0);
		wait_core();
		chk({28'h0, strap_latched}, 32'h0000_0005);
		chk_defaults();
		// energy detect: sleep, periodic pulses, wake on activity
		wait_state(ST_NORMAL, 60);
		apb(1'b1, 8'h74, 32'h0000_8000);
		wait_state(ST_ENERGY_SLEEP, 6);
		chk({30'h0, line_ctrl.link_active, line_ctrl.tx_enable}, 32'h0);
		for (i = 0; i < 4100 && line_ctrl.energy_pulse !== 1'b1; i++) @(posedge pclk);
		chk({30'h0, line_ctrl.energy_pulse, line_ctrl.tx_enable}, 32'h3);
		t0 = cycles;
		for (i = 0; i < 8 && line_ctrl.energy_pulse === 1'b1; i++) @(posedge pclk);
		for (i = 0; i < 4100 && line_ctrl.energy_pulse !== 1'b1; i++) @(posedge pclk);
		chk(32'(cycles - t0), `PULSE_PERIOD_CYCLES);
		chk({29'h0, power_state}, {29'h0, ST_ENERGY_SLEEP});
		i_board.set_energy(1'b1);
		wait_state(ST_POWER_UP, 6);
		wait_state(ST_NORMAL, 50);
		chk({31'h0, line_ctrl.link_active}, 32'h1);
		give_verdict();
	end
endmodule : test_phy_reset_power_control
